// *** in_ep_cfg_pkg.sv ***
// Purpose: Constants for the IN endpoint buffer configuration block.
// Assumes: APB slave, 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses inside the block.
// Functional notes
// - Per-endpoint 8-bit writable buffer size byte.
// - X and Y buffers share one size.
// - Per-endpoint 8-bit writable X base byte.
// - Base is 11 bits, byte gives 10:3.
// - Base low three bits forced zero.
// - Config bits interpreted per isochronous type.
// - Enable activates endpoint; setup reception independent.
// - Toggle inverts after good IN data stage.
// - Double buffer alternates X/Y, else X only.
// - Stall bit answers every transaction STALL.
package in_ep_cfg_pkg;
  localparam logic [7:0] OFS_SIZE = 8'h00;
  localparam logic [7:0] OFS_XBASE = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] SIZE_RESET = 8'h00;
  localparam logic [7:0] XBASE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int BIT_ACTIVE = 7;
  localparam int BIT_ISO = 6;
  localparam int BIT_TOGGLE = 5;
  localparam int BIT_DUAL = 4;
  localparam int BIT_STALL = 3;
  localparam int BIT_IRQ_EN = 2;
  localparam int UNIT_SHIFT = 3;
  localparam int BASE_WIDTH = 11;
  localparam int LEN_WIDTH = 11;
  typedef enum logic [1:0] {
    HS_NONE = 2'b00,
    HS_DATA = 2'b01,
    HS_NAK = 2'b10,
    HS_STALL = 2'b11
  } handshake_e;
endpackage

// *** in_ep_buffer_sel.sv ***
`timescale 1ns/1ns
// Purpose: Tracks which of the X/Y buffers an IN endpoint serves next.
// Assumes: Done pulse marks a successful IN data stage with a valid packet.
// Notes: Returns to X whenever dual buffering is off.
module in_ep_buffer_sel
  import in_ep_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Control.
  input wire logic dual_buffer_select,
  input wire logic data_stage_done,
  // Result.
  output logic use_y
);
  logic use_y_reg;
  logic use_y_next;

  // Alternate after each good stage; single mode pins X.
  always_comb
  begin
    use_y_next = use_y_reg;
    if (!dual_buffer_select)
    begin
      use_y_next = 1'b0;
    end
    else if (data_stage_done)
    begin
      use_y_next = ~use_y_reg;
    end
  end

  // Registered buffer pointer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      use_y_reg <= 1'b0;
    end
    else
    begin
      use_y_reg <= use_y_next;
    end
  end

  assign use_y = use_y_reg;
endmodule

// *** in_ep_buffer_config.sv ***
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ns
// Purpose: Buffer size, X base and configuration bytes for one IN endpoint.
// Assumes: APB master from the microcontroller; buffer manager is on-chip logic.
// Notes: Zero-wait APB slave; unmapped addresses read zero and flag pslverr.
//   Only byte lane 0 is stored, so pstrb[0] alone qualifies a write.
//   The status word is read-only and shows live state, not a sticky log.
//   The buffer manager raises at most one request per cycle.
module in_ep_buffer_config
  import in_ep_cfg_pkg::*;
(
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Buffer manager events.
  input wire logic transaction_req,
  input wire logic setup_stage,
  input wire logic packet_ready,
  input wire logic data_stage_done,
  // Buffer manager view of the endpoint.
  output logic [BASE_WIDTH-1:0] x_base_addr,
  output logic [LEN_WIDTH-1:0] buffer_length,
  output logic use_y_buffer,
  output logic data1_pid,
  output logic is_iso,
  output logic endpoint_irq_enable,
  output logic [1:0] handshake
);
  // Stored bytes and their next values.
  logic [7:0] buffer_length_units_reg;
  logic [7:0] buffer_length_units_next;
  logic [7:0] x_base_upper_bits_reg;
  logic [7:0] x_base_upper_bits_next;
  logic [7:0] config_reg;
  logic [7:0] config_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [1:0] handshake_reg;
  logic [1:0] handshake_next;
  // Bus strobes and decode.
  logic wr_en;
  logic rd_en;
  logic hit;
  logic use_y;
  logic [3:0] sel;

  // One-hot register select shared by the write, read and error paths.
  // Bit 0 size, bit 1 X base, bit 2 configuration, bit 3 status.
  // A compare chain keeps room for the Y base and count bytes next door.
  function automatic logic [3:0] reg_select(input logic [7:0] a);
    reg_select = 4'h0;
    if (a == OFS_SIZE)
    begin
      reg_select = 4'h1;
    end
    else if (a == OFS_XBASE)
    begin
      reg_select = 4'h2;
    end
    else if (a == OFS_CONFIG)
    begin
      reg_select = 4'h4;
    end
    else if (a == OFS_STATUS)
    begin
      reg_select = 4'h8;
    end
  endfunction

  // Any selected register makes the address valid.
  function automatic logic mapped(input logic [7:0] a);
    mapped = |reg_select(a);
  endfunction

  // Access phase completes at once, so writes land in one edge.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign sel = reg_select(paddr);
  assign hit = mapped(paddr);
  // An access to an unmapped offset is flagged and any write there is dropped.
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Register writes; the toggle bit also flips under buffer manager control.
  always_comb
  begin
    buffer_length_units_next = buffer_length_units_reg;
    x_base_upper_bits_next = x_base_upper_bits_reg;
    config_next = config_reg;
    if (wr_en && pstrb[0])
    begin
      // Writes to the status offset are accepted but dropped.
      if (sel[0])
      begin
        buffer_length_units_next = pwdata[7:0];
      end
      else if (sel[1])
      begin
        x_base_upper_bits_next = pwdata[7:0];
      end
      else if (sel[2])
      begin
        config_next = pwdata[7:0];
      end
    end
    // The hardware flip wins over a same-cycle software write to keep PID order.
    // It is held off while stalled or disabled, as no data stage completes then.
    if (data_stage_done && !config_reg[BIT_STALL] && config_reg[BIT_ACTIVE])
    begin
      config_next[BIT_TOGGLE] = ~config_reg[BIT_TOGGLE];
    end
  end

  // Read mux; status word reports the buffer currently in use.
  // Data is loaded at the setup edge so the access phase sees a flopped value.
  always_comb
  begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite)
    begin
      prdata_next = 32'h0000_0000;
      if (sel[0])
      begin
        prdata_next[7:0] = buffer_length_units_reg;
      end
      else if (sel[1])
      begin
        prdata_next[7:0] = x_base_upper_bits_reg;
      end
      else if (sel[2])
      begin
        prdata_next[7:0] = config_reg;
      end
      else if (sel[3])
      begin
        prdata_next[1:0] = {handshake_reg == HS_STALL, use_y};
      end
    end
  end

  // Handshake decision for each transaction request from the buffer manager.
  // Priority is stall, then setup, then enable, then data or NAK.
  // Setup ahead of enable lets a control endpoint take setup while disabled.
  // Isochronous endpoints never NAK; an empty buffer still sends data.
  always_comb
  begin
    handshake_next = HS_NONE;
    if (transaction_req)
    begin
      if (config_reg[BIT_STALL])
      begin
        handshake_next = HS_STALL;
      end
      else if (setup_stage)
      begin
        handshake_next = HS_DATA;
      end
      else if (!config_reg[BIT_ACTIVE])
      begin
        handshake_next = HS_NONE;
      end
      else if (packet_ready || config_reg[BIT_ISO])
      begin
        handshake_next = HS_DATA;
      end
      else
      begin
        handshake_next = HS_NAK;
      end
    end
  end

  // State registers.
  // The answer is registered so it stands one full cycle for the buffer manager.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_length_units_reg <= SIZE_RESET;
      x_base_upper_bits_reg <= XBASE_RESET;
      config_reg <= CONFIG_RESET;
      prdata_reg <= 32'h0000_0000;
      handshake_reg <= HS_NONE;
    end
    else
    begin
      buffer_length_units_reg <= buffer_length_units_next;
      x_base_upper_bits_reg <= x_base_upper_bits_next;
      config_reg <= config_next;
      prdata_reg <= prdata_next;
      handshake_reg <= handshake_next;
    end
  end

  // X/Y selection; the Y base is kept elsewhere, both share one length.
  // The pointer sits in its own module so the Y side can grow on its own.
  in_ep_buffer_sel u_sel (
    .pclk(pclk),
    .presetn(presetn),
    .dual_buffer_select(config_reg[BIT_DUAL]),
    .data_stage_done(data_stage_done),
    .use_y(use_y)
  );

  // Outputs other than pready and pslverr come straight from flip-flops.
  // The length is in bytes, so a size byte of zero gives an empty buffer.
  assign prdata = prdata_reg;
  assign x_base_addr = {x_base_upper_bits_reg, 3'b000};
  assign buffer_length = {buffer_length_units_reg, 3'b000};
  assign use_y_buffer = use_y;
  assign data1_pid = config_reg[BIT_TOGGLE];
  assign is_iso = config_reg[BIT_ISO];
  assign endpoint_irq_enable = config_reg[BIT_IRQ_EN];
  assign handshake = handshake_reg;
endmodule

// *** in_ep_cfg_props.sv ***
`timescale 1ns/1ns
// Purpose: Port assertions for the endpoint configuration block.
// Assumes: Zero-wait APB, handshake one cycle after a request.
// Notes: Toggle and buffer side move only on done or a write.
module in_ep_cfg_props
  import in_ep_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB requests.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  // Buffer manager requests.
  input wire logic transaction_req,
  input wire logic setup_stage,
  input wire logic data_stage_done,
  // Endpoint view.
  input wire logic [10:0] x_base_addr,
  input wire logic [10:0] buffer_length,
  input wire logic data1_pid,
  input wire logic use_y_buffer,
  input wire logic is_iso,
  input wire logic [1:0] handshake
);
  logic wr;
  logic [7:0] wb;
  // A write only counts with the low byte strobe set.
  assign wr = psel && penable && pwrite && pstrb[0];
  assign wb = pwdata[7:0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_req;
    transaction_req && setup_stage;
  endsequence
  size_wr_a: assert property (wr && paddr == OFS_SIZE |=> buffer_length == {$past(wb), 3'h0})
    else $error("size write lost");
  base_wr_a: assert property (wr && paddr == OFS_XBASE |=> x_base_addr == {$past(wb), 3'h0})
    else $error("base write lost");
  base_low_a: assert property (x_base_addr[2:0] == 3'h0)
    else $error("base low bits set");
  len_units_a: assert property (buffer_length[2:0] == 3'h0)
    else $error("length not in units");
  iso_wr_a: assert property (wr && paddr == OFS_CONFIG && pwdata[BIT_ISO] |=> is_iso)
    else $error("iso bit lost");
  setup_ans_a: assert property (setup_req |=> handshake inside {HS_DATA, HS_STALL})
    else $error("setup not answered");
  tog_hold_a: assert property (!data_stage_done && !wr |=> $stable(data1_pid))
    else $error("toggle moved alone");
  // Clearing dual mode forces X one edge after the write lands.
  side_hold_a: assert property (!data_stage_done && !wr && !$past(wr) |=> $stable(use_y_buffer))
    else $error("buffer side moved alone");
endmodule
bind in_ep_buffer_config in_ep_cfg_props chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .transaction_req(transaction_req), .setup_stage(setup_stage),
  .data_stage_done(data_stage_done), .x_base_addr(x_base_addr),
  .buffer_length(buffer_length), .data1_pid(data1_pid), .use_y_buffer(use_y_buffer),
  .is_iso(is_iso), .handshake(handshake));

// *** in_ep_bm_model.sv ***
`timescale 1ns/1ns
// Purpose: Buffer manager side that asks for handshakes and ends stages.
// Assumes: Handshake stands for the cycle after the request edge.
// Notes: Released levels show their inverse so stale values never help.
module in_ep_bm_model
(
  // Clock and answer.
  input wire logic pclk,
  input wire logic [1:0] handshake,
  // Requests.
  output logic transaction_req,
  output logic setup_stage,
  output logic packet_ready,
  output logic data_stage_done
);
  // Quiet at time zero.
  initial
  begin
    transaction_req = 1'b0;
    setup_stage = 1'b0;
    packet_ready = 1'b0;
    data_stage_done = 1'b0;
  end
  // A setup stage is offered whatever the enable bit holds.
  task ask(input logic s, input logic p, output logic [1:0] h);
    transaction_req <= 1'b1;
    setup_stage <= s;
    packet_ready <= p;
    @(posedge pclk);
    transaction_req <= 1'b0;
    setup_stage <= ~s;
    packet_ready <= ~p;
    // The answer stands for the whole next cycle; take it at that edge.
    @(posedge pclk);
    h = handshake;
  endtask
  // One good data stage.
  task fire;
    data_stage_done <= 1'b1;
    @(posedge pclk);
    data_stage_done <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
// Purpose: Register and handshake tests of the endpoint block.
// Assumes: Zero-wait APB slave.
// Notes: The cycle limit is far above the run length.
module tb_top;
  import in_ep_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic treq, sstg, prdy, done, use_y, d1, iso, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [10:0] xb, blen;
  logic [1:0] hs, hv;
  logic [11:0] tab [5];
  int miscompares, n_compared, cyc;
  in_ep_buffer_config dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .transaction_req(treq), .setup_stage(sstg),
    .packet_ready(prdy), .data_stage_done(done), .x_base_addr(xb), .buffer_length(blen),
    .use_y_buffer(use_y), .data1_pid(d1), .is_iso(iso), .endpoint_irq_enable(irq),
    .handshake(hs));
  in_ep_bm_model bm (.pclk(pclk), .handshake(hs), .transaction_req(treq),
    .setup_stage(sstg), .packet_ready(prdy), .data_stage_done(done));
  task report_and_stop;
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Clock, and a cycle limit so a hang still ends in the verdict.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      miscompares++;
      report_and_stop;
    end
  end
  // Table rows: config byte, setup, packet, expected handshake.
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, presetn} = '0;
    tab = '{12'h009, 12'h004, 12'h802, 12'hC01, 12'h88F};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    pstrb <= 4'hF;
    @(posedge pclk);
    apb(0, OFS_CONFIG, 8'h00);
    chk(rd, CONFIG_RESET);
    for (int i = 0; i < 3; i++)
    begin
      apb(1, OFS_SIZE, 8'h01 << (i * 3) | 8'h18);
      apb(0, OFS_SIZE, 8'h00);
      chk(rd, 8'h01 << (i * 3) | 8'h18);
      chk(blen, {8'h01 << (i * 3) | 8'h18, 3'h0});
    end
    apb(1, OFS_XBASE, 8'hA5);
    chk(xb, 11'h528);
    pstrb <= 4'h0;
    apb(1, OFS_XBASE, 8'h11);
    chk(xb, 11'h528);
    pstrb <= 4'hF;
    apb(0, 8'h10, 8'h00);
    chk({er, rd[30:0]}, 32'h80000000);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, OFS_CONFIG, tab[i][11:4]);
      bm.ask(tab[i][3], tab[i][2], hv);
      chk(hv, tab[i][1:0]);
    end
    apb(1, OFS_CONFIG, 8'h94);
    chk({iso, irq}, 2'b01);
    for (int i = 1; i < 3; i++)
    begin
      bm.fire;
      chk({d1, use_y}, {2{i[0]}});
      apb(0, OFS_STATUS, 8'h00);
      chk(rd, {31'h0, i[0]});
    end
    apb(1, OFS_CONFIG, 8'h80);
    bm.fire;
    chk({d1, use_y}, 2'b10);
    report_and_stop;
  end
endmodule
